// [pkg/drapc_defines.svh]
// Notes on behaviour
// [RULE_01] DAC A code changes on the serial edge carrying the write's last data bit.
// [RULE_02] DAC B code changes on the serial edge carrying the write's last data bit.
// [RULE_03] DAC A code is 10-bit unsigned, right justified in bits 9..0.
// [RULE_04] DAC B code is 10-bit unsigned, right justified, same scaling as A.
// [RULE_05] DAC A and its buffer are powered while bit 15 is one.
// [RULE_06] DAC B and its buffer are powered while bit 14 is one.
// [RULE_07] Each op amp is powered while its own enable bit in 15..13 is one.
// [RULE_08] Enable bits exist once; writes through either DAC register change both views.
// [RULE_09] Bits 12..10 and absent code bits are don't-care.
// [RULE_10] Control byte: ref select 7..6, off 5, on 4, detector enable 3, threshold 2..0.
// [RULE_11] Control byte resets to zero, reference buffer off.
// [RULE_12] Ref select: 00 off/high-Z, 01 1.25 V, 10 2.048 V, 11 2.5 V.
// [RULE_13] Writing one to group-off clears ADC enable and all DAC and amp enables.
// [RULE_14] Writing zero to group-off changes nothing.
// [RULE_15] Writing one to group-on sets ADC enable and all DAC and amp enables.
// [RULE_16] Writing zero to group-on changes nothing.
// [RULE_17] Group-on wins when both group bits are written as one.
// [RULE_18] Detector is powered while its enable bit is one.
// [RULE_19] Host sets the ADC enable whenever it uses the detector.
// [RULE_20] Bits 2..0 choose the detector threshold.
// [RULE_21] Threshold: top bit zero gives 0 mV; 100..111 give 50..200 mV.
// [RULE_22] ADC powers down whenever its enable clears, group-off included.
// [RULE_23] Group bits act once per write; host never clears them.
`ifndef DRAPC_DEFINES_SVH
`define DRAPC_DEFINES_SVH

// ----------------------------------------
// command byte
// ----------------------------------------
`define DRAPC_CMD_START_BIT 7
`define DRAPC_CMD_READ_BIT 6
`define DRAPC_CMD_LEN 5'h08

// ----------------------------------------
// register addresses
// ----------------------------------------
`define DRAPC_ADDR_DAC_A 6'h10
`define DRAPC_ADDR_DAC_B 6'h11
`define DRAPC_ADDR_REF_CTRL 6'h12

// ----------------------------------------
// data lengths in serial bits
// ----------------------------------------
`define DRAPC_LEN_DAC 5'h10
`define DRAPC_LEN_REF 5'h08
`define DRAPC_LEN_NONE 5'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define DRAPC_DAC_EN_HI 15
`define DRAPC_DAC_EN_LO 13
`define DRAPC_DAC_CODE_HI 9
`define DRAPC_REF_SEL_HI 7
`define DRAPC_REF_SEL_LO 6
`define DRAPC_REF_OFF_BIT 5
`define DRAPC_REF_ON_BIT 4
`define DRAPC_REF_DET_BIT 3
`define DRAPC_REF_THR_HI 2

// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define DRAPC_RST_DAC_CODE 10'h000
`define DRAPC_RST_EN 3'h0
`define DRAPC_ALL_EN 3'h7
`define DRAPC_RST_REF_SEL 2'h0
`define DRAPC_RST_THR 3'h0
`define DRAPC_THR_0MV 8'h00
`define DRAPC_THR_50MV 8'h32
`define DRAPC_THR_100MV 8'h64
`define DRAPC_THR_150MV 8'h96
`define DRAPC_THR_200MV 8'hC8

`endif

// [pkg/drapc_pkg.sv]
package drapc_pkg;

   typedef enum logic [1:0] {
      ST_CMD,
      ST_WRITE,
      ST_READ,
      ST_DONE
   } drapc_state_t;

   typedef enum logic [1:0] {
      REF_OFF,
      REF_1V25,
      REF_2V048,
      REF_2V5
   } drapc_ref_t;

   // analog control seen by the analog macros
   typedef struct packed {
      logic [9:0] dacACode;
      logic [9:0] dacBCode;
      logic dacAPowerEnable;
      logic dacBPowerEnable;
      logic amp1PowerEnable;
      logic amp2PowerEnable;
      logic amp3PowerEnable;
      drapc_ref_t refVoltageSel;
      logic refBufferOn;
      logic detectorPowerEnable;
      logic [2:0] thresholdSelect;
      logic [7:0] thresholdMv;
      logic adcPowerOnPulse;
      logic adcPowerOffPulse;
   } drapc_analog_t;

   // serial pin group, raw at the pins or already in the mclk domain
   typedef struct packed {
      logic sclk;
      logic csN;
      logic din;
   } drapc_serial_t;

   typedef struct packed {
      drapc_state_t state;
      logic [4:0] bitCnt;
      logic [4:0] dataLen;
      logic [5:0] addr;
      logic [15:0] shift;
      logic [15:0] rdShift;
      logic sclkPrev;
      logic [2:0] enables;
      logic [9:0] dacA;
      logic [9:0] dacB;
      logic [1:0] refSel;
      logic detEn;
      logic [2:0] thr;
      logic dout;
      logic doutOeN;
      drapc_analog_t analog;
   } drapc_regs_t;

endpackage : drapc_pkg

// [rtl/drapc_sync.sv]
`timescale 1ns/10ps
module drapc_sync (
   input wire logic mclk,
   input wire logic reset_n,
   input wire drapc_pkg::drapc_serial_t pinsAsync,
   output drapc_pkg::drapc_serial_t pinsSync
);
   import drapc_pkg::*;

   logic [2:0] stage1_q;
   logic [2:0] stage2_q;
   logic [2:0] raw;

   assign raw = pinsAsync;
   assign pinsSync = stage2_q;

   // ----------------------------------------
   // two-flop synchroniser per pin
   // ----------------------------------------
   // idle level is high so chip select reads deasserted through reset
   genvar i;
   generate
      for (i = 0; i < 3; i++) begin : g_bit
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               stage1_q[i] <= 1'b1;
               stage2_q[i] <= 1'b1;
            end else begin
               stage1_q[i] <= raw[i];
               stage2_q[i] <= stage1_q[i];
            end
         end
      end
   endgenerate

endmodule : drapc_sync

// [rtl/drapc_top.sv]
`timescale 1ns/10ps
`include "drapc_defines.svh"
module drapc_top (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic csN,
   input wire logic din,
   output logic dout,
   output logic doutOeN,
   output drapc_pkg::drapc_analog_t analog
);
   import drapc_pkg::*;

   drapc_serial_t pinsAsync;
   drapc_serial_t pins;
   drapc_regs_t q;
   drapc_regs_t d;
   logic rise;
   logic fall;
   logic [15:0] inWord;

   assign pinsAsync.sclk = sclk;
   assign pinsAsync.csN = csN;
   assign pinsAsync.din = din;

   drapc_sync u_sync (
      .mclk(mclk),
      .reset_n(reset_n),
      .pinsAsync(pinsAsync),
      .pinsSync(pins)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [4:0] lenOf(input logic [5:0] a);
      case (a)
         `DRAPC_ADDR_DAC_A: lenOf = `DRAPC_LEN_DAC;
         `DRAPC_ADDR_DAC_B: lenOf = `DRAPC_LEN_DAC;
         `DRAPC_ADDR_REF_CTRL: lenOf = `DRAPC_LEN_REF;
         default: lenOf = `DRAPC_LEN_NONE;
      endcase
   endfunction : lenOf

   // read words are left justified so the shifter always sends bit 15 first
   function automatic logic [15:0] readOf(input drapc_regs_t r, input logic [5:0] a);
      case (a)
         `DRAPC_ADDR_DAC_A: readOf = {r.enables, 3'h0, r.dacA}; // RULE_08
         `DRAPC_ADDR_DAC_B: readOf = {r.enables, 3'h0, r.dacB}; // RULE_08
         // group action bits read back as zero, they hold no state
         `DRAPC_ADDR_REF_CTRL: readOf = {r.refSel, 2'h0, r.detEn, r.thr, 8'h00};
         default: readOf = 16'h0000;
      endcase
   endfunction : readOf

   function automatic logic [7:0] thrMv(input logic [2:0] t);
      case (t)
         3'h4: thrMv = `DRAPC_THR_50MV; // RULE_21
         3'h5: thrMv = `DRAPC_THR_100MV;
         3'h6: thrMv = `DRAPC_THR_150MV;
         3'h7: thrMv = `DRAPC_THR_200MV;
         default: thrMv = `DRAPC_THR_0MV; // RULE_21
      endcase
   endfunction : thrMv

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      d = q;
      d.analog.adcPowerOnPulse = 1'b0;
      d.analog.adcPowerOffPulse = 1'b0;
      d.sclkPrev = pins.sclk;
      rise = pins.sclk & ~q.sclkPrev;
      fall = ~pins.sclk & q.sclkPrev;
      inWord = {q.shift[14:0], pins.din};

      if (pins.csN) begin
         // raising chip select early drops a partial write
         d.state = ST_CMD;
         d.bitCnt = 5'h00;
         d.doutOeN = 1'b1;
         d.dout = 1'b0;
      end else begin
         case (q.state)
            ST_CMD: begin
               if (rise) begin
                  d.shift = inWord;
                  d.bitCnt = q.bitCnt + 5'h01;
                  if (q.bitCnt == `DRAPC_CMD_LEN - 5'h01) begin
                     d.bitCnt = 5'h00;
                     d.addr = inWord[5:0];
                     d.dataLen = lenOf(inWord[5:0]);
                     if (!inWord[`DRAPC_CMD_START_BIT] || lenOf(inWord[5:0]) == `DRAPC_LEN_NONE) begin
                        d.state = ST_DONE;
                     end else if (inWord[`DRAPC_CMD_READ_BIT]) begin
                        d.rdShift = readOf(q, inWord[5:0]);
                        d.state = ST_READ;
                     end else begin
                        d.state = ST_WRITE;
                     end
                  end
               end
            end
            ST_WRITE: begin
               if (rise) begin
                  d.shift = inWord;
                  d.bitCnt = q.bitCnt + 5'h01;
                  if (q.bitCnt == q.dataLen - 5'h01) begin
                     d.state = ST_DONE;
                     case (q.addr)
                        `DRAPC_ADDR_DAC_A: begin
                           d.dacA = inWord[`DRAPC_DAC_CODE_HI:0]; // RULE_01 RULE_03
                           d.enables = inWord[`DRAPC_DAC_EN_HI:`DRAPC_DAC_EN_LO]; // RULE_08
                           // bits 12..10 dropped
                           // RULE_09
                        end
                        `DRAPC_ADDR_DAC_B: begin
                           d.dacB = inWord[`DRAPC_DAC_CODE_HI:0]; // RULE_02 RULE_04
                           d.enables = inWord[`DRAPC_DAC_EN_HI:`DRAPC_DAC_EN_LO]; // RULE_08
                        end
                        `DRAPC_ADDR_REF_CTRL: begin
                           d.refSel = inWord[`DRAPC_REF_SEL_HI:`DRAPC_REF_SEL_LO]; // RULE_10
                           d.detEn = inWord[`DRAPC_REF_DET_BIT]; // RULE_10
                           d.thr = inWord[`DRAPC_REF_THR_HI:0]; // RULE_10 RULE_20
                           // group bits act once here and are never stored
                           // RULE_23
                           if (inWord[`DRAPC_REF_ON_BIT]) begin
                              d.enables = `DRAPC_ALL_EN; // RULE_15 RULE_17
                              d.analog.adcPowerOnPulse = 1'b1; // RULE_15
                           end else if (inWord[`DRAPC_REF_OFF_BIT]) begin
                              d.enables = `DRAPC_RST_EN; // RULE_13
                              d.analog.adcPowerOffPulse = 1'b1; // RULE_13 RULE_22
                           end
                           // zeros in both group bits leave enables alone
                           // RULE_14 RULE_16
                        end
                        default: d.state = ST_DONE;
                     endcase
                  end
               end
            end
            ST_READ: begin
               if (fall) begin
                  d.dout = q.rdShift[15];
                  d.rdShift = {q.rdShift[14:0], 1'b0};
                  d.doutOeN = 1'b0;
               end
               if (rise) begin
                  d.bitCnt = q.bitCnt + 5'h01;
                  if (q.bitCnt == q.dataLen - 5'h01) begin
                     d.state = ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               // one access per chip-select frame; last read bit stays on the pin
               d.state = ST_DONE;
            end
            default: d.state = ST_CMD;
         endcase
      end

      // ----------------------------------------
      // analog control outputs
      // ----------------------------------------
      d.analog.dacACode = d.dacA; // RULE_03
      d.analog.dacBCode = d.dacB; // RULE_04
      d.analog.dacAPowerEnable = d.enables[2]; // RULE_05
      d.analog.dacBPowerEnable = d.enables[1]; // RULE_06
      d.analog.amp3PowerEnable = d.enables[2]; // RULE_07
      d.analog.amp2PowerEnable = d.enables[1]; // RULE_07
      d.analog.amp1PowerEnable = d.enables[0]; // RULE_07
      d.analog.refVoltageSel = drapc_ref_t'(d.refSel); // RULE_12
      d.analog.refBufferOn = (d.refSel != `DRAPC_RST_REF_SEL); // RULE_12
      d.analog.detectorPowerEnable = d.detEn; // RULE_18
      d.analog.thresholdSelect = d.thr; // RULE_20
      d.analog.thresholdMv = thrMv(d.thr); // RULE_21
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         q.state <= ST_CMD;
         q.bitCnt <= 5'h00;
         q.dataLen <= `DRAPC_LEN_NONE;
         q.addr <= 6'h00;
         q.shift <= 16'h0000;
         q.rdShift <= 16'h0000;
         q.sclkPrev <= 1'b1;
         q.enables <= `DRAPC_RST_EN;
         q.dacA <= `DRAPC_RST_DAC_CODE;
         q.dacB <= `DRAPC_RST_DAC_CODE;
         q.refSel <= `DRAPC_RST_REF_SEL; // RULE_11
         q.detEn <= 1'b0; // RULE_11
         q.thr <= `DRAPC_RST_THR; // RULE_11
         q.dout <= 1'b0;
         q.doutOeN <= 1'b1;
         q.analog <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout = q.dout;
   assign doutOeN = q.doutOeN;
   assign analog = q.analog;

endmodule : drapc_top

// [verification/drapc_chk_sva.sv]
`timescale 1ns/10ps
module drapc_chk (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic csN,
   input wire drapc_pkg::drapc_analog_t analog
);
   import drapc_pkg::*;
   logic [7:0] thrExp;
   assign thrExp = analog.thresholdSelect[2] ? 8'h32 * ({6'h00, analog.thresholdSelect[1:0]} + 8'h01) : 8'h00;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   // ------
   // sequences
   // ------
   // five cycles covers the pin sync plus the output register
   sequence csIdle;
      csN [*5];
   endsequence
   sequence allOn;
      analog.dacAPowerEnable && analog.dacBPowerEnable && analog.amp1PowerEnable;
   endsequence
   sequence allOff;
      !analog.dacAPowerEnable && !analog.dacBPowerEnable && !analog.amp1PowerEnable;
   endsequence
   // ------
   // assertions
   // ------
   chk_quiet_frame: assert property (csIdle |=> $stable(analog))
      else $error("analog changed outside a frame");
   chk_group_excl: assert property (!(analog.adcPowerOnPulse && analog.adcPowerOffPulse))
      else $error("both adc pulses at once");
   chk_on_once: assert property (analog.adcPowerOnPulse |=> !analog.adcPowerOnPulse)
      else $error("adc on pulse too long");
   chk_on_sets: assert property (analog.adcPowerOnPulse |-> ##[0:1] allOn)
      else $error("group on left an enable low");
   chk_off_clears: assert property (analog.adcPowerOffPulse |-> ##[0:1] allOff)
      else $error("group off left an enable high");
   chk_en_alias: assert property (analog.dacAPowerEnable == analog.amp3PowerEnable
      && analog.dacBPowerEnable == analog.amp2PowerEnable)
      else $error("shared enable views differ");
   chk_ref_buffer: assert property (analog.refBufferOn == (analog.refVoltageSel != REF_OFF))
      else $error("reference buffer state wrong");
   chk_thr_map: assert property (analog.thresholdMv == thrExp)
      else $error("threshold millivolts wrong");
endmodule : drapc_chk

bind drapc_top drapc_chk u_drapc_chk (.mclk(mclk), .reset_n(reset_n), .csN(csN), .analog(analog));

// [verification/drapc_host.sv]
`timescale 1ns/10ps
module drapc_host (
   input wire logic mclk,
   output logic sclk,
   output logic csN,
   output logic din,
   input wire logic dout,
   input wire logic doutOeN
);
   initial begin
      sclk = 1'b1;
      csN = 1'b1;
      din = 1'b0;
   end
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step
   // ------
   // frame: six mclk per half period keeps each pin event past the sync
   // ------
   task automatic frame(input logic [7:0] cmd, input logic [15:0] data, input int len, input int sent,
                        output logic [15:0] rd);
      rd = 16'h0000;
      step(1);
      csN = 1'b0;
      step(6);
      for (int i = 0; i < sent; i++) begin
         sclk = 1'b0;
         din = (i < 8) ? cmd[7 - i] : data[len + 7 - i];
         step(6);
         if (i >= 8) rd[len + 7 - i] = doutOeN ? 1'bx : dout;
         sclk = 1'b1;
         step(6);
      end
      csN = 1'b1;
      din = ~din; // released line must not keep its last value
      step(6);
   endtask : frame
endmodule : drapc_host

// [verification/test_dac_ref_analog_power_ctrl.sv]
`timescale 1ns/10ps
module test_dac_ref_analog_power_ctrl;
   import drapc_pkg::*;
   localparam logic [7:0] GRP [5] = '{8'h18, 8'h08, 8'h20, 8'h00, 8'h38};
   logic mclk, reset_n, sclk, csN, din, dout, doutOeN;
   drapc_analog_t analog;
   int failures, checks_done, onCnt, offCnt, eOn, eOff;
   logic [9:0] mA, mB;
   logic [2:0] en, thr;
   logic [1:0] rs;
   logic det;
   logic [15:0] rd;
   logic [31:0] r;

   always #50 mclk = ~mclk;
   // pulses counted mid-cycle, away from the edge that launches them
   always @(negedge mclk) begin
      if (analog.adcPowerOnPulse === 1'b1) onCnt++;
      if (analog.adcPowerOffPulse === 1'b1) offCnt++;
   end

   drapc_top u_drapc_top (.mclk(mclk), .reset_n(reset_n), .sclk(sclk), .csN(csN), .din(din), .dout(dout),
      .doutOeN(doutOeN), .analog(analog));
   drapc_host u_drapc_host (.mclk(mclk), .sclk(sclk), .csN(csN), .din(din), .dout(dout), .doutOeN(doutOeN));

   // ------
   // helpers
   // ------
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic drapc_analog_t expA();
      drapc_analog_t e;
      e = '0;
      e.dacACode = mA;
      e.dacBCode = mB;
      e.dacAPowerEnable = en[2];
      e.amp3PowerEnable = en[2];
      e.dacBPowerEnable = en[1];
      e.amp2PowerEnable = en[1];
      e.amp1PowerEnable = en[0];
      e.refVoltageSel = drapc_ref_t'(rs);
      e.refBufferOn = (rs != 2'h0);
      e.detectorPowerEnable = det;
      e.thresholdSelect = thr;
      e.thresholdMv = thr[2] ? 8'h32 * ({6'h00, thr[1:0]} + 8'h01) : 8'h00;
      return e;
   endfunction : expA
   task automatic checkOut();
      drapc_analog_t v;
      v = analog;
      v.adcPowerOnPulse = 1'b0;
      v.adcPowerOffPulse = 1'b0;
      check(v, expA());
   endtask : checkOut
   task automatic wrDac(input logic b, input logic [15:0] v);
      u_drapc_host.frame({2'b10, 5'h08, b}, v, 16, 24, rd);
      en = v[15:13];
      if (b) mB = v[9:0];
      else mA = v[9:0];
   endtask : wrDac
   task automatic wrRef(input logic [7:0] v);
      u_drapc_host.frame(8'h92, {8'h00, v}, 8, 16, rd);
      rs = v[7:6];
      det = v[3];
      thr = v[2:0];
      if (v[4]) begin
         en = 3'h7;
         eOn++;
      end else if (v[5]) begin
         en = 3'h0;
         eOff++;
      end
   endtask : wrRef
   // group bits and bits 12..10 read back as zero
   task automatic rdCheck(input logic [5:0] a);
      logic [15:0] exp;
      exp = (a == 6'h12) ? {8'h00, rs, 2'b00, det, thr} : {en, 3'h0, (a[0] ? mB : mA)};
      u_drapc_host.frame({2'b11, a}, 16'h0000, (a == 6'h12) ? 8 : 16, (a == 6'h12) ? 16 : 24, rd);
      check(rd, exp);
   endtask : rdCheck
   task automatic results();
      if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results

   // ------
   // sequence
   // ------
   initial begin
      {mclk, reset_n, failures, checks_done, onCnt, offCnt, eOn, eOff} = '0;
      {mA, mB, en, thr, rs, det} = '0;
      void'($urandom(8));
      repeat (12) @(posedge mclk);
      #1 reset_n = 1'b1;
      checkOut();
      check(doutOeN, 1'b1);
      rdCheck(6'h12);
      wrDac(1'b0, 16'h9D55);
      checkOut();
      rdCheck(6'h11);
      wrDac(1'b1, 16'h63FF);
      checkOut();
      rdCheck(6'h10);
      for (int k = 0; k < 8; k++) begin
         wrRef({k[1:0], 1'b0, k[0], k[0], k[2:0]});
         checkOut();
         rdCheck(6'h12);
      end
      // detector only ever enabled while the adc is up
      for (int k = 0; k < 5; k++) begin
         wrRef(GRP[k]);
         checkOut();
         check(onCnt, eOn);
         check(offCnt, eOff);
      end
      u_drapc_host.frame(8'h90, 16'h0000, 16, 23, rd);
      checkOut();
      // start bit low: whole frame ignored
      u_drapc_host.frame(8'h10, 16'h0000, 16, 24, rd);
      checkOut();
      // unknown address: no DAC, enable or control register written
      u_drapc_host.frame(8'h93, 16'h0000, 8, 16, rd);
      checkOut();
      for (int k = 0; k < 30; k++) begin
         r = $urandom;
         case (r[1:0])
            2'h0: wrDac(1'b0, r[31:16]);
            2'h1: wrDac(1'b1, r[31:16]);
            default: wrRef({r[15:13], r[12] | r[11], r[11:8]});
         endcase
         checkOut();
         rdCheck({4'h4, (r[3:2] == 2'h3) ? 2'h0 : r[3:2]});
      end
      check(onCnt, eOn);
      check(offCnt, eOff);
      results();
   end

   // nearly four times the expected run length
   initial begin
      #8000000;
      failures++;
      results();
   end
endmodule : test_dac_ref_analog_power_ctrl
